// >>> core/rot_pkg.sv
// Package of the RC oscillator trim control block: register map, field layout,
// reset values and the carrier structs shared by the design.
// Assumes a 32-bit word register port with byte offsets.

package rot_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_CONTROL = 5'h00;
	localparam logic [4:0] OFF_STATUS = 5'h04;
	localparam logic [4:0] OFF_MASKED = 5'h08;
	localparam logic [4:0] OFF_MASK = 5'h0c;
	localparam logic [4:0] OFF_RAW = 5'h10;
	localparam logic [4:0] OFF_CLEAR = 5'h14;
	localparam logic [4:0] OFF_CLKCFG = 5'h18;
	localparam logic [4:0] OFF_SOFTRST = 5'h1c;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CODE_W = 8;
	localparam int CTRL_W = 14;
	localparam int STAT_CODE_LSB = 2;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_READY = 1;
	localparam int CLK_REF_SEL = 2;
	localparam int CLK_DIV_RST = 3;
	localparam int SOFT_RST_BIT = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [13:0] CTRL_RST = 14'h07f1;
	localparam logic [1:0] MASK_RST = 2'h3;
	localparam logic [3:0] CLKCFG_RST = 4'h4;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rsvd_keep;
		logic [7:0] external_trim_code;
		logic osc_power_down;
		logic ext_code_en;
		logic cal_en;
		logic ref_clk_en;
	} rot_ctrl_s;

	typedef struct packed {
		logic clk_ready;
		logic cal_done;
		logic [7:0] code;
	} rot_ana_s;

endpackage

// >>> core/rot_trim_ctrl.sv
// RC oscillator trim control: registers, calibration capture, interrupts.
// Assumes an analog oscillator core outside the clock domain, and a
// register master that issues one-cycle read or write strobes.
// Function
// RL1 - Hold 8-bit external trim code in control bits 11:4, reset 0x7F.
// RL2 - Control bit 2 picks calibrated code (0) or external code (1).
// RL3 - Control bit 3 powers oscillator down when 1; resets to 0.
// RL4 - Control bit 1 enables calibration when 1; resets to 0.
// RL5 - Control bit 0 enables calibration reference clock; resets to 1.
// RL6 - On calibration done set status bit 1, show code in bits 9:2.
// RL7 - Status bit 0 reads 1 while the fast oscillator is ready.
// RL8 - Raw register: bit 1 clock ready, bit 0 calibration done, unmasked.
// RL9 - Masked bit is 1 only when raw is 1 and mask is 0.
// RL10 - Mask bits suppress interrupts when 1; both reset to 1.
// RL11 - Writing 1 to clear bit 1 or 0 clears that raw flag.
// RL12 - Clock bit 2 selects full reference (1, reset) or halved (0).
// RL13 - Writing 1 to clock bit 3 resets the divider; 0 does nothing.
// RL14 - Writing 1 to soft reset bit 0 resets the whole module; the three synchroniser stages keep their contents.
// RL15 - Software keeps reserved writable fields at their reset values.
// RL16 - Raw flags set on rising condition; interrupt is OR of masked bits.
// RL17 - Clear bits self-clear after one cycle, giving one clear pulse.
//
// Added by the designer: the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module rot_trim_ctrl #(
	parameter int CODE_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ana_cal_done,
	input wire logic [CODE_W-1:0] ana_measured_trim_code,
	input wire logic ana_clk_ready,
	output logic [CODE_W-1:0] osc_trim_code,
	output logic osc_power_down,
	output logic osc_cal_enable,
	output logic osc_ref_clk_enable,
	output logic osc_ref_full_sel,
	output logic osc_div_reset,
	output logic irq
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (CODE_W != rot_pkg::CODE_W) begin : g_bad_width
		$error("trim code width must match the register field");
	end

	localparam int AW = CODE_W + 2;
	rot_pkg::rot_ctrl_s ctrl_ff;
	logic [rot_pkg::IRQ_W-1:0] mask_ff;
	logic [rot_pkg::IRQ_W-1:0] raw_ff;
	logic [rot_pkg::IRQ_W-1:0] clr_ff;
	logic [rot_pkg::IRQ_W-1:0] nxt_raw;
	logic ref_sel_ff;
	logic [1:0] clk_rsvd_ff;
	logic div_rst_ff;
	logic soft_rst_ff;
	logic [AW-1:0] sync1_ff;
	logic [AW-1:0] sync2_ff;
	logic [AW-1:0] sync3_ff;
	rot_pkg::rot_ana_s ana_ff;
	rot_pkg::rot_ana_s ana_prev_ff;
	logic [CODE_W-1:0] cal_code_ff;
	logic [CODE_W-1:0] nxt_trim;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;
	logic pd_ff;
	logic cal_en_ff;
	logic ref_en_ff;
	logic full_ff;
	logic irq_ff;
	logic [CODE_W-1:0] trim_code_ff;
	logic done_rise;
	logic ready_rise;
	logic wr_ctrl;

	assign wr_ctrl = reg_wr && (reg_addr == rot_pkg::OFF_CONTROL);
	// ------------------------------------------------------------
	// Soft reset
	// ------------------------------------------------------------
	// The soft reset lasts one cycle and clears the control, clock, mask, flag,
	// filter and capture registers, including itself, but not the three
	// synchroniser stages; the register reads back as zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			soft_rst_ff <= 1'b0;
		end else if (clk_en) begin
			soft_rst_ff <= reg_wr && !soft_rst_ff
				&& (reg_addr == rot_pkg::OFF_SOFTRST)
				&& reg_wdata[rot_pkg::SOFT_RST_BIT]; // RL14
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= rot_pkg::CTRL_RST;
		end else if (clk_en) begin
			if (soft_rst_ff) begin
				ctrl_ff <= rot_pkg::CTRL_RST; // RL14
			end else if (wr_ctrl) begin
				ctrl_ff <= reg_wdata[rot_pkg::CTRL_W-1:0]; // RL1 RL3 RL4 RL5
			end
		end
	end

	// ------------------------------------------------------------
	// Clock register and divider reset pulse
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ref_sel_ff <= rot_pkg::CLKCFG_RST[rot_pkg::CLK_REF_SEL];
			clk_rsvd_ff <= rot_pkg::CLKCFG_RST[1:0];
			div_rst_ff <= 1'b0;
		end else if (clk_en) begin
			div_rst_ff <= 1'b0;
			if (soft_rst_ff) begin
				ref_sel_ff <= rot_pkg::CLKCFG_RST[rot_pkg::CLK_REF_SEL];
				clk_rsvd_ff <= rot_pkg::CLKCFG_RST[1:0];
			end else if (reg_wr && (reg_addr == rot_pkg::OFF_CLKCFG)) begin
				ref_sel_ff <= reg_wdata[rot_pkg::CLK_REF_SEL]; // RL12
				clk_rsvd_ff <= reg_wdata[1:0];
				div_rst_ff <= reg_wdata[rot_pkg::CLK_DIV_RST]; // RL13
			end
		end
	end

	// ------------------------------------------------------------
	// Mask and clear registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_ff <= rot_pkg::MASK_RST;
		end else if (clk_en) begin
			if (soft_rst_ff) begin
				mask_ff <= rot_pkg::MASK_RST; // RL10
			end else if (reg_wr && (reg_addr == rot_pkg::OFF_MASK)) begin
				mask_ff <= reg_wdata[rot_pkg::IRQ_W-1:0];
			end
		end
	end
	// Clear bits hold for exactly one cycle after the write.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clr_ff <= '0;
		end else if (clk_en) begin
			if (!soft_rst_ff && reg_wr && (reg_addr == rot_pkg::OFF_CLEAR)) begin
				clr_ff <= reg_wdata[rot_pkg::IRQ_W-1:0]; // RL11
			end else begin
				clr_ff <= '0; // RL17
			end
		end
	end

	// ------------------------------------------------------------
	// Analog input synchroniser
	// ------------------------------------------------------------
	// A bit only counts as changed once stages two and three agree, which
	// filters a single-cycle glitch from the analog side.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else if (clk_en) begin
			sync1_ff <= {ana_clk_ready, ana_cal_done, ana_measured_trim_code};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	for (genvar i = 0; i < AW; i++) begin : g_filter
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				ana_ff[i] <= 1'b0;
			end else if (clk_en) begin
				if (soft_rst_ff) begin
					ana_ff[i] <= 1'b0;
				end else if (sync2_ff[i] == sync3_ff[i]) begin
					ana_ff[i] <= sync3_ff[i];
				end
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ana_prev_ff <= '0;
		end else if (clk_en) begin
			ana_prev_ff <= soft_rst_ff ? '0 : ana_ff;
		end
	end
	assign done_rise = ana_ff.cal_done && !ana_prev_ff.cal_done;
	assign ready_rise = ana_ff.clk_ready && !ana_prev_ff.clk_ready;

	// ------------------------------------------------------------
	// Calibration result capture
	// ------------------------------------------------------------
	// The code is taken on the done edge so a later wander of the analog
	// code bus does not disturb the reported result.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cal_code_ff <= '0;
		end else if (clk_en) begin
			if (soft_rst_ff) begin
				cal_code_ff <= '0;
			end else if (done_rise) begin
				cal_code_ff <= ana_ff.code; // RL6
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------
	always_comb begin
		nxt_raw = raw_ff & ~clr_ff; // RL11
		if (done_rise) begin
			nxt_raw[rot_pkg::IRQ_DONE] = 1'b1; // RL16
		end
		if (ready_rise) begin
			nxt_raw[rot_pkg::IRQ_READY] = 1'b1; // RL16
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			raw_ff <= '0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			raw_ff <= soft_rst_ff ? '0 : nxt_raw; // RL8
			irq_ff <= !soft_rst_ff && (|(nxt_raw & ~mask_ff)); // RL16
		end
	end

	// ------------------------------------------------------------
	// Oscillator drive
	// ------------------------------------------------------------
	always_comb begin
		if (ctrl_ff.ext_code_en) begin
			nxt_trim = ctrl_ff.external_trim_code; // RL2
		end else begin
			nxt_trim = cal_code_ff; // RL2
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trim_code_ff <= rot_pkg::CTRL_RST[11:4];
			pd_ff <= 1'b0;
			cal_en_ff <= 1'b0;
			ref_en_ff <= 1'b1;
			full_ff <= 1'b1;
		end else if (clk_en) begin
			trim_code_ff <= nxt_trim;
			pd_ff <= ctrl_ff.osc_power_down; // RL3
			cal_en_ff <= ctrl_ff.cal_en; // RL4
			ref_en_ff <= ctrl_ff.ref_clk_en; // RL5
			full_ff <= ref_sel_ff; // RL12
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		nxt_rdata = '0;
		case (reg_addr)
			rot_pkg::OFF_CONTROL: nxt_rdata[rot_pkg::CTRL_W-1:0] = ctrl_ff;
			rot_pkg::OFF_STATUS: begin
				nxt_rdata[rot_pkg::STAT_CODE_LSB +: CODE_W] = cal_code_ff; // RL6
				nxt_rdata[1] = ana_ff.cal_done; // RL6
				nxt_rdata[0] = ana_ff.clk_ready; // RL7
			end
			rot_pkg::OFF_MASKED: nxt_rdata[1:0] = raw_ff & ~mask_ff; // RL9
			rot_pkg::OFF_MASK: nxt_rdata[1:0] = mask_ff;
			rot_pkg::OFF_RAW: nxt_rdata[1:0] = raw_ff; // RL8
			rot_pkg::OFF_CLEAR: nxt_rdata[1:0] = clr_ff;
			rot_pkg::OFF_CLKCFG: nxt_rdata[3:0] = {1'b0, ref_sel_ff, clk_rsvd_ff};
			default: nxt_rdata = '0;
		endcase
	end
	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else if (clk_en) begin
			rdata_ff <= reg_rd ? nxt_rdata : '0;
		end
	end

	assign reg_rdata = rdata_ff;
	assign osc_trim_code = trim_code_ff;
	assign osc_power_down = pd_ff;
	assign osc_cal_enable = cal_en_ff;
	assign osc_ref_clk_enable = ref_en_ff;
	assign osc_ref_full_sel = full_ff;
	assign osc_div_reset = div_rst_ff;
	assign irq = irq_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_ctrl_write;
		clk_en && wr_ctrl && !soft_rst_ff;
	endsequence
	sequence s_settled;
		clk_en [*2];
	endsequence
	a_ext_code_store: assert property (s_ctrl_write |=> // RL1
		ctrl_ff.external_trim_code == $past(reg_wdata[11:4]))
		else $error("external trim code not stored");
	a_trim_source_mux: assert property (s_ctrl_write ##1 s_settled |-> // RL2
		osc_trim_code == ($past(ctrl_ff.ext_code_en) ? $past(ctrl_ff.external_trim_code)
		: $past(cal_code_ff)))
		else $error("trim code source wrong");
	a_power_down_out: assert property (s_ctrl_write ##1 s_settled |-> // RL3
		osc_power_down == $past(reg_wdata[3], 2))
		else $error("power down not driven");
	a_cal_enable_out: assert property (s_ctrl_write ##1 s_settled |-> // RL4
		osc_cal_enable == $past(reg_wdata[1], 2))
		else $error("calibration enable not driven");
	a_ref_enable_out: assert property (s_ctrl_write ##1 s_settled |-> // RL5
		osc_ref_clk_enable == $past(reg_wdata[0], 2))
		else $error("reference clock enable not driven");
	a_done_capture: assert property (clk_en && done_rise && !soft_rst_ff |=> // RL6
		cal_code_ff == $past(ana_ff.code) && raw_ff[rot_pkg::IRQ_DONE])
		else $error("calibration result not captured");
	a_ready_status: assert property (clk_en && reg_rd && // RL7
		reg_addr == rot_pkg::OFF_STATUS |=> reg_rdata[0] == $past(ana_ff.clk_ready))
		else $error("ready status wrong");
	a_masked_read: assert property (clk_en && reg_rd && // RL9
		reg_addr == rot_pkg::OFF_MASKED |=>
		reg_rdata[1:0] == $past(raw_ff & ~mask_ff))
		else $error("masked status wrong");
	a_irq_level: assert property (clk_en ##1 clk_en |-> // RL10
		irq == (!$past(soft_rst_ff) && (|($past(nxt_raw) & ~$past(mask_ff)))))
		else $error("interrupt level wrong");
	a_clear_pulse: assert property ((clk_en && |clr_ff && // RL17
		!(reg_wr && reg_addr == rot_pkg::OFF_CLEAR)) ##1 clk_en |-> clr_ff == '0)
		else $error("clear did not self-clear");
	a_clear_flag: assert property (clk_en && clr_ff[0] && !done_rise // RL11
		&& !soft_rst_ff |=> !raw_ff[0])
		else $error("flag not cleared");
	a_div_reset: assert property (clk_en && reg_wr && !soft_rst_ff && // RL13
		reg_addr == rot_pkg::OFF_CLKCFG |=> osc_div_reset == $past(reg_wdata[3]))
		else $error("divider reset pulse wrong");
	a_soft_reset: assert property (clk_en && soft_rst_ff |=> // RL14
		ctrl_ff == rot_pkg::CTRL_RST && raw_ff == '0 && mask_ff == rot_pkg::MASK_RST)
		else $error("soft reset incomplete");
	a_ref_select: assert property (clk_en ##1 clk_en |-> // RL12
		osc_ref_full_sel == $past(ref_sel_ff))
		else $error("reference select not driven");
endmodule // rot_trim_ctrl

`default_nettype wire

// >>> sim/rot_osc_model.sv
// Behavioural model of the analog RC oscillator core behind the trim block.
// Assumes the block's oscillator controls arrive registered on ref_clk.

`timescale 1ns/1ps
`default_nettype none

module rot_osc_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_down,
	input wire logic cal_enable,
	input wire logic ref_clk_enable,
	input wire logic [7:0] lat,
	input wire logic [7:0] cal_code,
	output logic clk_ready,
	output logic cal_done,
	output logic [7:0] measured_code
);
	logic [7:0] rdy_cnt_ff;
	logic [7:0] cal_cnt_ff;
	logic cal_run;

	// --------------------------------------------------------------
	// Oscillator start-up and calibration
	// --------------------------------------------------------------
	// Calibration only runs with its reference clock on and the core powered.
	assign cal_run = cal_enable && ref_clk_enable && !power_down;
	// Outside a calibration the code lines show the inverse, never a stale match.
	assign measured_code = cal_run ? cal_code : ~cal_code;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst || power_down) begin
			rdy_cnt_ff <= 8'h00;
			clk_ready <= 1'b0;
		end else if (rdy_cnt_ff < lat) begin
			rdy_cnt_ff <= rdy_cnt_ff + 8'h01;
		end else begin
			clk_ready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst || !cal_run) begin
			cal_cnt_ff <= 8'h00;
			cal_done <= 1'b0;
		end else if (cal_cnt_ff < lat) begin
			cal_cnt_ff <= cal_cnt_ff + 8'h01;
		end else begin
			cal_done <= 1'b1;
		end
	end
endmodule // rot_osc_model

`default_nettype wire

// >>> sim/rot_trim_ctrl_tb.sv
// Self-checking bench of the RC oscillator trim control block.
// Assumes the block and the oscillator model share one 25 MHz clock.

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module rot_trim_ctrl_tb;
	typedef struct {string nm; logic [31:0] v;} rot_exp_s;
	logic ref_clk, rst, clk_en, reg_wr, reg_rd, irq, rd_seen;
	logic [4:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic ana_cal_done, ana_clk_ready;
	logic [7:0] ana_code, osc_trim_code, lat, cal_code, cc, ec;
	logic osc_power_down, osc_cal_enable, osc_ref_clk_enable, osc_ref_full_sel, osc_div_reset;
	int miscompares, num_checks, cycles, div_pulses, n;
	rot_exp_s exp_q[$];
	rot_exp_s e;

	rot_trim_ctrl u_rot_trim_ctrl (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ana_cal_done(ana_cal_done), .ana_measured_trim_code(ana_code),
		.ana_clk_ready(ana_clk_ready), .osc_trim_code(osc_trim_code),
		.osc_power_down(osc_power_down), .osc_cal_enable(osc_cal_enable),
		.osc_ref_clk_enable(osc_ref_clk_enable), .osc_ref_full_sel(osc_ref_full_sel),
		.osc_div_reset(osc_div_reset), .irq(irq));

	rot_osc_model u_rot_osc_model (.ref_clk(ref_clk), .rst(rst), .power_down(osc_power_down),
		.cal_enable(osc_cal_enable), .ref_clk_enable(osc_ref_clk_enable), .lat(lat),
		.cal_code(cal_code), .clk_ready(ana_clk_ready), .cal_done(ana_cal_done),
		.measured_code(ana_code));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// Read monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		rd_seen <= reg_rd && clk_en;
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end

	// Read data stand only in the cycle after the strobe, so it is sampled mid-cycle.
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1) begin
			e = exp_q.pop_front();
			`CHK(e.nm, e.v, reg_rdata)
		end
		if (osc_div_reset === 1'b1)
			div_pulses++;
	end

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] v, input string nm);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back('{nm, v});
		@(posedge ref_clk);
	endtask

	task automatic idle(input int k);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (k) @(posedge ref_clk);
	endtask

	// Leaves the bus idle for a cycle, then waits on the interrupt line with a bound of 200 cycles.
	task automatic wait_irq();
		idle(1);
		for (n = 0; n < 200 && irq !== 1'b1; n++)
			@(posedge ref_clk);
		`CHK("irq raised", 1'b1, irq)
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 32'h0000_0000;
		rd_seen = 1'b0;
		lat = 8'h1e;
		cal_code = 8'h00;
		void'($urandom(78));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(rot_pkg::OFF_CONTROL, 32'h0000_07f1, "ctrl reset");
		rd(rot_pkg::OFF_STATUS, 32'h0000_0000, "status reset");
		rd(rot_pkg::OFF_MASKED, 32'h0000_0000, "masked reset");
		rd(rot_pkg::OFF_MASK, 32'h0000_0003, "mask reset");
		rd(rot_pkg::OFF_RAW, 32'h0000_0000, "raw reset");
		rd(rot_pkg::OFF_CLEAR, 32'h0000_0000, "clear reset");
		rd(rot_pkg::OFF_CLKCFG, 32'h0000_0004, "clock reset");
		rd(rot_pkg::OFF_SOFTRST, 32'h0000_0000, "soft reset reg");
		rd(5'h03, 32'h0000_0000, "unmapped");
		idle(1);
		@(negedge ref_clk);
		// The trim source resets to internal, and the calibrated code resets to zero.
		`CHK("trim out reset", 8'h00, osc_trim_code)
		`CHK("outputs reset", 5'b00110, {osc_power_down, osc_cal_enable, osc_ref_clk_enable,
			osc_ref_full_sel, irq})
		@(posedge ref_clk);
		// Slow start-up of the oscillator, still masked.
		idle(40);
		rd(rot_pkg::OFF_STATUS, 32'h0000_0001, "status ready");
		rd(rot_pkg::OFF_RAW, 32'h0000_0002, "raw ready");
		rd(rot_pkg::OFF_MASKED, 32'h0000_0000, "masked off");
		`CHK("irq masked", 1'b0, irq)
		wr(rot_pkg::OFF_MASK, 32'h0000_0000);
		wait_irq();
		rd(rot_pkg::OFF_MASKED, 32'h0000_0002, "masked ready");
		wr(rot_pkg::OFF_CLEAR, 32'h0000_0002);
		idle(2);
		rd(rot_pkg::OFF_RAW, 32'h0000_0000, "raw cleared");
		rd(rot_pkg::OFF_CLEAR, 32'h0000_0000, "clear self");
		`CHK("irq cleared", 1'b0, irq)
		// Prompt calibration with an internal code.
		lat <= 8'h04;
		cc = 8'($urandom);
		cal_code <= cc;
		wr(rot_pkg::OFF_CONTROL, 32'h0000_07f3);
		wait_irq();
		rd(rot_pkg::OFF_STATUS, {22'h0, cc, 2'b11}, "status done");
		rd(rot_pkg::OFF_RAW, 32'h0000_0001, "raw done");
		rd(rot_pkg::OFF_MASKED, 32'h0000_0001, "masked done");
		`CHK("internal trim", cc, osc_trim_code)
		`CHK("cal enable out", 1'b1, osc_cal_enable)
		// External code, calibration off.
		ec = 8'($urandom);
		wr(rot_pkg::OFF_CONTROL, {20'h0, ec, 4'h5});
		rd(rot_pkg::OFF_CONTROL, {20'h0, ec, 4'h5}, "ctrl ext");
		wr(rot_pkg::OFF_CLEAR, 32'h0000_0001);
		idle(3);
		`CHK("external trim", ec, osc_trim_code)
		`CHK("cal off", 1'b0, osc_cal_enable)
		`CHK("irq after clear", 1'b0, irq)
		// Power down drops the ready level, power up raises a fresh event.
		wr(rot_pkg::OFF_CONTROL, {20'h0, ec, 4'hd});
		idle(8);
		`CHK("power down", 1'b1, osc_power_down)
		rd(rot_pkg::OFF_STATUS, {22'h0, cc, 2'b00}, "status down");
		wr(rot_pkg::OFF_CONTROL, {20'h0, ec, 4'h4});
		wait_irq();
		rd(rot_pkg::OFF_RAW, 32'h0000_0002, "raw ready again");
		`CHK("ref clock off", 1'b0, osc_ref_clk_enable)
		// Divider controls, back to back.
		div_pulses = 0;
		wr(rot_pkg::OFF_CLKCFG, 32'h0000_0008);
		wr(rot_pkg::OFF_CLKCFG, 32'h0000_0000);
		wr(rot_pkg::OFF_CLKCFG, 32'h0000_000c);
		idle(4);
		`CHK("divider pulses", 2, div_pulses)
		rd(rot_pkg::OFF_CLKCFG, 32'h0000_0004, "clock readback");
		wr(rot_pkg::OFF_CLKCFG, 32'h0000_0000);
		idle(3);
		`CHK("half ref", 1'b0, osc_ref_full_sel)
		// A write while the clock enable is low is not taken.
		clk_en <= 1'b0;
		wr(rot_pkg::OFF_MASK, 32'h0000_0003);
		idle(2);
		clk_en <= 1'b1;
		wr(5'h02, 32'hffff_ffff);
		rd(rot_pkg::OFF_MASK, 32'h0000_0000, "mask frozen");
		// Soft reset of the module, all but the three synchroniser stages.
		wr(rot_pkg::OFF_SOFTRST, 32'h0000_0001);
		idle(4);
		rd(rot_pkg::OFF_CONTROL, 32'h0000_07f1, "ctrl soft");
		rd(rot_pkg::OFF_MASK, 32'h0000_0003, "mask soft");
		rd(rot_pkg::OFF_CLKCFG, 32'h0000_0004, "clock soft");
		idle(2);
		`CHK("trim soft", 8'h00, osc_trim_code)
		`CHK("full ref soft", 1'b1, osc_ref_full_sel)
		`CHK("irq soft", 1'b0, irq)
		idle(2);
		wrap_up();
	end
endmodule // rot_trim_ctrl_tb

`default_nettype wire
